// file: rtl/dars_defines.vh
`ifndef DARS_DEFINES_VH
`define DARS_DEFINES_VH
// sequencer states
`define DARS_ST_IDLE    3'h0
`define DARS_ST_RDSTART 3'h1
`define DARS_ST_WRSTART 3'h2
`define DARS_ST_ACCESS  3'h3
`define DARS_ST_WAIT    3'h4
`define DARS_ST_FORCED  3'h5
`define DARS_ST_PRECHG  3'h6
`define DARS_ST_HIDDEN  3'h7
// cycles the row strobe stays active in an access
`define DARS_ACCESS_CYCLES 2'h2
// cycles of forced refresh in mode 1
`define DARS_FORCED_CYCLES 2'h3
// precharge cycles between consecutive strobes
`define DARS_PRECHG_CYCLES 2'h2
// controller mode bit values
`define DARS_MODE_ACCESS 1'b0
`define DARS_MODE_FORCED 1'b1
`endif

// file: rtl/dars_sequencer.v
`timescale 1ns/1ns
`include "dars_defines.vh"

// What this block does
// - chip select plus address strobe starts access
// - direction or status bit picks read/write
// - hidden refresh when timebase high, unselected
// - flag with no access forces mode 1
// - access during forced refresh waits, then runs
// - forced refresh allowed during foreign accesses
// - one extra cycle, separately for read/write
// - no extra wait in hidden refresh
// - read strobe starts earlier than write only with delay select low
// - read strobe in T1 or T2 by select
// - mode output drives mode 1 only forced
// - active-low ready inserts wait states
// - read wait input adds one read wait
module dars_sequencer #(
	// counter width and phase lengths in clock cycles
	parameter                    CNT_W         = 2,
	parameter [CNT_W-1:0]        ACCESS_CYCLES = `DARS_ACCESS_CYCLES,
	parameter [CNT_W-1:0]        FORCED_CYCLES = `DARS_FORCED_CYCLES,
	parameter [CNT_W-1:0]        PRECHG_CYCLES = `DARS_PRECHG_CYCLES
) (
	// clock and reset
	input  wire sys_clk_i,
	input  wire rst_i,
	// processor bus
	input  wire chip_select_n_i,
	input  wire addr_latch_strobe_i,
	input  wire transfer_direction_i,
	input  wire use_status_bit_i,
	input  wire cycle_status_bit_n_i,
	// configuration
	input  wire read_strobe_delay_select_i,
	input  wire read_wait_insert_n_i,
	input  wire write_wait_insert_n_i,
	// refresh
	input  wire refresh_timebase_i,
	input  wire refresh_request_input_n_i,
	// outputs
	output reg  row_strobe_request_n_o,
	output reg  controller_mode_bit_o,
	output reg  cpu_ready_out_n_o,
	output reg  access_busy_o
);

	// sequencer states
	localparam [2:0] ST_IDLE    = `DARS_ST_IDLE;
	localparam [2:0] ST_RDSTART = `DARS_ST_RDSTART;
	localparam [2:0] ST_WRSTART = `DARS_ST_WRSTART;
	localparam [2:0] ST_ACCESS  = `DARS_ST_ACCESS;
	localparam [2:0] ST_WAIT    = `DARS_ST_WAIT;
	localparam [2:0] ST_FORCED  = `DARS_ST_FORCED;
	localparam [2:0] ST_PRECHG  = `DARS_ST_PRECHG;
	localparam [2:0] ST_HIDDEN  = `DARS_ST_HIDDEN;
	localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

	reg  [2:0]       state_q;
	reg  [2:0]       state_d;
	reg  [CNT_W-1:0] cnt_q;
	reg  [CNT_W-1:0] cnt_d;
	reg              is_read_q;
	reg              is_read_d;
	reg              extra_q;
	reg              extra_d;
	reg              pend_q;
	reg              pend_d;
	reg              strobe_d;
	reg              mode_d;
	reg              ready_n_d;
	reg              busy_d;

	wire selected = ~chip_select_n_i;
	wire start    = selected & addr_latch_strobe_i;
	// status bit low means read in max mode
	wire is_read  = use_status_bit_i ? ~cycle_status_bit_n_i : ~transfer_direction_i;
	wire rf_req   = ~refresh_request_input_n_i;
	wire want_ext = is_read ? ~read_wait_insert_n_i : ~write_wait_insert_n_i;

	// last cycle of any counted phase
	function cnt_last;
		input [CNT_W-1:0] cnt;
		begin
			cnt_last = (cnt == CNT_ONE);
		end
	endfunction

	always @* begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		is_read_d = is_read_q;
		extra_d   = extra_q;
		pend_d    = pend_q;
		strobe_d  = 1'b0;
		mode_d    = `DARS_MODE_ACCESS;
		ready_n_d = 1'b0;
		case (state_q)
		ST_IDLE: begin
			if (start) begin
				is_read_d = is_read;
				extra_d   = want_ext;
				// delay select low lets a read strobe start in T1
				if (is_read && !read_strobe_delay_select_i) begin
					state_d  = ST_ACCESS;
					strobe_d = 1'b1;
					cnt_d    = ACCESS_CYCLES;
				end else if (is_read) begin
					state_d = ST_RDSTART;
				end else begin
					state_d = ST_WRSTART;
				end
			end else if (rf_req) begin
				// foreign accesses do not block this path
				state_d = ST_FORCED;
				mode_d  = `DARS_MODE_FORCED;
				cnt_d   = FORCED_CYCLES;
				pend_d  = 1'b0;
			end else if (refresh_timebase_i && addr_latch_strobe_i && !selected) begin
				state_d  = ST_HIDDEN;
				strobe_d = 1'b1;
				cnt_d    = ACCESS_CYCLES;
			end
		end
		ST_RDSTART: begin
			state_d  = ST_ACCESS;
			strobe_d = 1'b1;
			cnt_d    = ACCESS_CYCLES;
		end
		ST_WRSTART: begin
			state_d  = ST_ACCESS;
			strobe_d = 1'b1;
			cnt_d    = ACCESS_CYCLES;
		end
		ST_ACCESS: begin
			strobe_d = 1'b1;
			if (cnt_q == ACCESS_CYCLES && extra_q) begin
				ready_n_d = 1'b1;
			end
			if (cnt_last(cnt_q)) begin
				if (extra_q) begin
					state_d = ST_WAIT;
				end else begin
					state_d  = ST_PRECHG;
					strobe_d = 1'b0;
					cnt_d    = PRECHG_CYCLES;
				end
			end else begin
				cnt_d = cnt_q - CNT_ONE;
			end
		end
		ST_WAIT: begin
			state_d  = ST_PRECHG;
			cnt_d    = PRECHG_CYCLES;
			extra_d  = 1'b0;
		end
		ST_HIDDEN: begin
			strobe_d = 1'b1;
			if (cnt_last(cnt_q)) begin
				state_d  = ST_PRECHG;
				strobe_d = 1'b0;
				cnt_d    = PRECHG_CYCLES;
			end else begin
				cnt_d = cnt_q - CNT_ONE;
			end
		end
		ST_FORCED: begin
			mode_d = `DARS_MODE_FORCED;
			// a start here is parked until precharge is over
			if (start) begin
				pend_d    = 1'b1;
				is_read_d = is_read;
				extra_d   = want_ext;
			end
			if (start || pend_q) begin
				ready_n_d = 1'b1;
			end
			if (cnt_last(cnt_q)) begin
				state_d = ST_PRECHG;
				mode_d  = `DARS_MODE_ACCESS;
				cnt_d   = PRECHG_CYCLES;
			end else begin
				cnt_d = cnt_q - CNT_ONE;
			end
		end
		ST_PRECHG: begin
			ready_n_d = pend_q;
			if (cnt_last(cnt_q)) begin
				if (pend_q) begin
					pend_d   = 1'b0;
					state_d  = ST_ACCESS;
					strobe_d = 1'b1;
					cnt_d    = ACCESS_CYCLES;
					ready_n_d = 1'b1;
				end else begin
					state_d = ST_IDLE;
				end
			end else begin
				cnt_d = cnt_q - CNT_ONE;
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
		busy_d = (state_d != ST_IDLE);
	end

	// sequencer state
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// phase counter
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= {CNT_W{1'b0}};
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// direction of the access in flight
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			is_read_q <= 1'b0;
		end else begin
			is_read_q <= is_read_d;
		end
	end

	// extra wait wanted for the access in flight
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			extra_q <= 1'b0;
		end else begin
			extra_q <= extra_d;
		end
	end

	// access parked behind a forced refresh
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend_q <= 1'b0;
		end else begin
			pend_q <= pend_d;
		end
	end

	// registered strobe keeps the controller input glitch free
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			row_strobe_request_n_o <= 1'b1;
		end else begin
			row_strobe_request_n_o <= ~strobe_d;
		end
	end

	// controller mode bit
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			controller_mode_bit_o <= `DARS_MODE_ACCESS;
		end else begin
			controller_mode_bit_o <= mode_d;
		end
	end

	// ready to the processor, low while no wait is wanted
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cpu_ready_out_n_o <= 1'b0;
		end else begin
			cpu_ready_out_n_o <= ready_n_d;
		end
	end

	// busy flag
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			access_busy_o <= 1'b0;
		end else begin
			access_busy_o <= busy_d;
		end
	end

endmodule

// file: sim/dars_sequencer_asserts.sv
`timescale 1ns/1ns
module dars_sequencer_asserts (
	input wire sys_clk_i, rst_i, chip_select_n_i, addr_latch_strobe_i, transfer_direction_i,
	input wire use_status_bit_i, cycle_status_bit_n_i, read_strobe_delay_select_i,
	input wire read_wait_insert_n_i, write_wait_insert_n_i, refresh_timebase_i,
	input wire refresh_request_input_n_i, row_strobe_request_n_o, controller_mode_bit_o,
	input wire cpu_ready_out_n_o, access_busy_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire rs = row_strobe_request_n_o;
	wire md = controller_mode_bit_o;
	wire ry = cpu_ready_out_n_o;
	wire rd = use_status_bit_i ? !cycle_status_bit_n_i : !transfer_direction_i;
	wire go = !access_busy_o & !chip_select_n_i & addr_latch_strobe_i;
	wire ew = rd ? !read_wait_insert_n_i : !write_wait_insert_n_i;
	wire er = go & rd & !read_strobe_delay_select_i;
	property p_early; er |=> !rs; endproperty
	a_early: assert property (p_early) else $error("early read strobe missing");
	property p_late; go & !er |=> rs ##1 !rs; endproperty
	a_late: assert property (p_late) else $error("late strobe wrong");
	property p_rwait; er & ew |-> ##2 ry ##1 !ry; endproperty
	a_rwait: assert property (p_rwait) else $error("read wait wrong");
	property p_hold; $fell(rs) |-> !rs ##1 !rs; endproperty
	a_hold: assert property (p_hold) else $error("strobe too short");
	property p_mode; $rose(md) |-> md [*3] ##1 !md; endproperty
	a_mode: assert property (p_mode) else $error("forced length wrong");
	property p_force; !access_busy_o & !refresh_request_input_n_i & !go |-> ##[1:2] md; endproperty
	a_force: assert property (p_force) else $error("no forced refresh");
	property p_hid; !access_busy_o & refresh_timebase_i & addr_latch_strobe_i &
		chip_select_n_i & refresh_request_input_n_i |-> ##[1:2] (!rs & !ry); endproperty
	a_hid: assert property (p_hid) else $error("hidden refresh wrong");
	property p_pend; md & !chip_select_n_i & addr_latch_strobe_i |=> ry; endproperty
	a_pend: assert property (p_pend) else $error("no wait in refresh");
endmodule

// file: sim/dars_ctl_model.sv
`timescale 1ns/1ns
module dars_ctl_model (
	input  wire clk_i, rst_i, tb_i, rs_n_i, cs_n_i, md_i,
	output reg  rq_n_o
);
	reg hid_q, tb_q, ras_q, cas_q;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			{hid_q, tb_q, rq_n_o, ras_q, cas_q} <= 5'h04;
		end else begin
			tb_q <= tb_i;
			ras_q <= !rs_n_i;
			cas_q <= ras_q; // column strobe only after the row hold
			if (tb_i & !rs_n_i & cs_n_i) hid_q <= 1'b1;
			if (tb_q & !tb_i) begin
				rq_n_o <= hid_q;
				hid_q <= 1'b0;
			end else if (md_i) begin
				rq_n_o <= 1'b1;
			end
		end
	end
endmodule

// file: sim/dars_sequencer_tb_top.sv
`timescale 1ns/1ns
module dars_sequencer_tb_top;
	reg sys_clk_i = 0, rst_i = 1, chip_select_n_i = 1, addr_latch_strobe_i = 0;
	reg transfer_direction_i = 0, use_status_bit_i = 0, cycle_status_bit_n_i = 1;
	reg read_strobe_delay_select_i = 0, read_wait_insert_n_i = 1, write_wait_insert_n_i = 1;
	reg refresh_timebase_i = 0, sw = 0;
	wire refresh_request_input_n_i, row_strobe_request_n_o, controller_mode_bit_o;
	wire cpu_ready_out_n_o, access_busy_o;
	integer err_total = 0, comparisons = 0, seed = 32'h48CAEBD0, n = 0, i;
	reg [2:0] exp_q[$];
	dars_sequencer dut (.*);
	dars_ctl_model ctl (.clk_i(sys_clk_i), .rst_i(rst_i), .tb_i(refresh_timebase_i),
		.rs_n_i(row_strobe_request_n_o), .cs_n_i(chip_select_n_i),
		.md_i(controller_mode_bit_o), .rq_n_o(refresh_request_input_n_i));
	initial forever #2 sys_clk_i = ~sys_clk_i;
	task chk(input [2:0] s, input [2:0] e);
		comparisons = comparisons + 1;
		if (s !== e) begin
			err_total = err_total + 1;
			$display("Error result expected %h seen %h", e, s);
		end
	endtask
	task print_verdict;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// p marks a start made during forced refresh: ready must drop before the strobe ends
	task acc(input rd, input d, input r, input w, input p);
		reg e, s;
		begin
			e = rd ? !r : !w;
			s = $random(seed);
			@(posedge sys_clk_i);
			{chip_select_n_i, addr_latch_strobe_i, read_strobe_delay_select_i} <= {2'h1, d};
			{use_status_bit_i, cycle_status_bit_n_i} <= {s, !rd};
			transfer_direction_i <= s ? $random(seed) : !rd;
			{read_wait_insert_n_i, write_wait_insert_n_i} <= {r, w};
			exp_q.push_back({e | p, 2'h2 + {1'b0, e}});
			@(posedge sys_clk_i);
			addr_latch_strobe_i <= 0;
			repeat (2) @(negedge sys_clk_i);
			repeat (40) if (access_busy_o !== 1'b0) @(negedge sys_clk_i);
			@(posedge sys_clk_i);
			chip_select_n_i <= 1;
		end
	endtask
	always @(negedge sys_clk_i) if (!rst_i) begin
		sw = sw | (cpu_ready_out_n_o & !chip_select_n_i);
		if (!row_strobe_request_n_o & !chip_select_n_i) n = n + 1;
		else if (n != 0) begin
			chk({sw, n[1:0]}, exp_q.pop_front());
			n = 0;
			sw = 0;
		end
	end
	initial begin
		#20000;
		err_total = err_total + 1;
		print_verdict;
	end
	initial begin
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 0;
		for (i = 0; i < 16; i = i + 1)
			acc($random(seed), $random(seed), $random(seed), $random(seed), 0);
		@(posedge sys_clk_i);
		{refresh_timebase_i, addr_latch_strobe_i} <= 2'h3;
		@(posedge sys_clk_i);
		addr_latch_strobe_i <= 0;
		repeat (6) @(posedge sys_clk_i);
		refresh_timebase_i <= 0;
		repeat (6) @(negedge sys_clk_i);
		chk({2'h0, controller_mode_bit_o}, 3'h0);
		@(posedge sys_clk_i);
		refresh_timebase_i <= 1;
		repeat (4) @(posedge sys_clk_i);
		refresh_timebase_i <= 0;
		repeat (10) if (controller_mode_bit_o !== 1'b1) @(negedge sys_clk_i);
		chk({2'h0, controller_mode_bit_o}, 3'h1);
		acc(0, 0, 1, 1, 1);
		repeat (4) @(posedge sys_clk_i);
		print_verdict;
	end
endmodule
bind dars_sequencer dars_sequencer_asserts u_chk (.*);
